// ===== verif/dac_sample_feeder_bench.sv
// Purpose: Self-checking bench for the serial converter sample feeder.
// Assumes: Audio reference at one eighth of ref_clk, far below the filter limit.
// Notes:   The bench plays the processor and the DMA master.
`timescale 1ns/1ps
module dac_sample_feeder_bench;
  import dsf_pkg::*;
  logic               ref_clk = 1'b0;
  logic               reset = 1'b1;
  logic [2:0]         audDiv = 3'h0;   // Audio reference divider.
  logic [DIV_W-1:0]   divRatio = 11'h002;
  dsf_pace_type       paceMode = PACE_UNTIMED;
  logic [TMR_W-1:0]   cmpPeriod = 16'h0000;
  logic               reqRouteDma = 1'b1;
  logic [3:0]         watermark = 4'h2;
  logic               wrValid = 1'b0;
  logic [CODE_W-1:0]  wrData = 10'h000;
  logic               overflowClr = 1'b0;
  logic               dmaReq, irqReq, emptyReq, wmReq, dmaTrig, ovf, sclk, syncN, sData;
  logic [9:0]         dacCode;
  logic [5:0]         dacPad;
  int                 dacFrames, cyc = 0, n_fail = 0, comparisons = 0;
  wire                audioRefClk = audDiv[2];

  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    audDiv <= audDiv + 3'h1;
    cyc <= cyc + 1;
  end

  dsf_feeder dsf_feeder_inst (.ref_clk(ref_clk), .reset(reset), .audioRefClk(audioRefClk),
    .divRatio(divRatio), .paceMode(paceMode), .cmpPeriod(cmpPeriod), .reqRouteDma(reqRouteDma),
    .watermark(watermark), .wrValid(wrValid), .wrData(wrData), .overflowClr(overflowClr),
    .dmaReq_q(dmaReq), .irqReq_q(irqReq), .emptyReq_q(emptyReq), .watermarkReq_q(wmReq),
    .dmaTrigger_q(dmaTrig), .overflowFlag_q(ovf), .dacSclk_q(sclk), .dacSyncN_q(syncN),
    .dacData_q(sData));
  dsf_dac_model dsf_dac_model_inst (.dacSclk(sclk), .dacSyncN(syncN), .dacData(sData),
    .code(dacCode), .pad(dacPad), .frames(dacFrames));

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Bounded wait: 0 sync, 1 bit clock, 2 empty request, 3 timer trigger.
  task automatic waitUntil(input int sel, input logic lvl);
    logic s;
    for (int i = 0; i < 12000; i++) begin
      @(posedge ref_clk);
      #1;
      case (sel)
        0: s = syncN;
        1: s = sclk;
        2: s = emptyReq;
        default: s = dmaTrig;
      endcase
      if (s === lvl) return;
    end
    n_fail++;
    $display("Error wait %0d expected %0h seen timeout", sel, lvl);
    report_and_stop();
  endtask

  task automatic put(input logic [9:0] d);
    @(posedge ref_clk);
    wrValid <= 1'b1;
    wrData <= d;
  endtask

  task automatic endPut;
    @(posedge ref_clk);
    wrValid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // Queue drained and the last frame finished.
  task automatic idle;
    waitUntil(2, 1'b1);
    repeat (3) @(posedge ref_clk);
    waitUntil(0, 1'b1);
  endtask

  task automatic clearOvf;
    @(posedge ref_clk);
    overflowClr <= 1'b1;
    endPut();
    @(posedge ref_clk);
    overflowClr <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check("overflowClr", ovf, 1'b0);
  endtask

  // Set-point writes with boundary codes, each sent once without pacing.
  task automatic tUntimed;
    logic [9:0] codes [3] = '{10'h2A5, 10'h3FF, 10'h001};
    int f;
    foreach (codes[k]) begin
      f = dacFrames;
      put(codes[k]);
      endPut();
      idle();
      check("frames", dacFrames - f, 1);
      check("code", dacCode, codes[k]);
      check("pad", dacPad, 6'h00);
    end
  endtask

  // Fill past capacity, watch routing, overflow and frame spacing.
  task automatic tFifo;
    int t0;
    @(posedge ref_clk);
    paceMode <= PACE_FIFO;
    reqRouteDma <= 1'b0;
    endPut();
    check("irqReq", irqReq, 1'b1);
    check("dmaReq", dmaReq, 1'b0);
    @(posedge ref_clk);
    reqRouteDma <= 1'b1;
    endPut();
    check("dmaReq", dmaReq, 1'b1);
    for (int i = 0; i < 10; i++) put(10'h100 + i);
    endPut();
    check("overflow", ovf, 1'b1);
    check("emptyReq", emptyReq, 1'b0);
    check("wmReq", wmReq, 1'b0);
    check("dmaReq", dmaReq, 1'b0);
    // The first frame may not have opened yet, so see it start before it ends.
    waitUntil(0, 1'b0);
    waitUntil(0, 1'b1);
    check("firstCode", dacCode, 10'h100);
    waitUntil(0, 1'b0);
    t0 = cyc;
    waitUntil(0, 1'b1);
    waitUntil(0, 1'b0);
    check("framePeriod", cyc - t0, 17 * 2 * 8);
    clearOvf();
    idle();
    check("dmaReqRefill", dmaReq, 1'b1);
  endtask

  // Act as the DMA master on each timer match, then overfill the single entry.
  task automatic tTimer;
    int t0;
    int f;
    @(posedge ref_clk);
    paceMode <= PACE_TIMER;
    cmpPeriod <= 16'h012B;
    f = dacFrames;
    waitUntil(3, 1'b1);
    t0 = cyc;
    for (int i = 0; i < 3; i++) begin
      put(10'h0C0 + i);
      endPut();
      waitUntil(3, 1'b0);
      waitUntil(3, 1'b1);
      check("trigGap", cyc - t0, 300 * (i + 1));
    end
    check("frames", dacFrames - f, 3);
    check("code", dacCode, 10'h0C2);
    check("overflow", ovf, 1'b0);
    idle();
    for (int i = 0; i < 3; i++) put(10'h0E0 + i);
    endPut();
    check("overflow", ovf, 1'b1);
    clearOvf();
    idle();
  endtask

  // Bit period follows the divide ratio, odd ratios included.
  task automatic tDiv;
    int t0;
    for (int r = 2; r <= 4; r++) begin
      @(posedge ref_clk);
      paceMode <= PACE_UNTIMED;
      divRatio <= DIV_W'(r);
      put(10'h155);
      endPut();
      waitUntil(0, 1'b0);
      waitUntil(1, 1'b0);
      waitUntil(1, 1'b1);
      t0 = cyc;
      waitUntil(1, 1'b0);
      waitUntil(1, 1'b1);
      check("bitPeriod", cyc - t0, 8 * r);
      waitUntil(0, 1'b1);
      check("code", dacCode, 10'h155);
    end
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    #1;
    check("rstSync", syncN, 1'b1);
    check("rstEmpty", emptyReq, 1'b1);
    check("rstWm", wmReq, 1'b1);
    check("rstOvf", ovf, 1'b0);
    @(posedge ref_clk);
    reset <= 1'b0;
    tUntimed();
    tFifo();
    tTimer();
    tDiv();
    report_and_stop();
  end
endmodule // dac_sample_feeder_bench

// ===== verif/dsf_dac_model.sv
// Purpose: Behavioural single-channel serial converter fed by the sample feeder.
// Assumes: Data is stable at the rising bit clock while sync is low.
// Notes:   Reports the last code, the six pad bits and a count of whole frames.
`timescale 1ns/1ps
module dsf_dac_model (
  // Serial link from the feeder.
  input  wire logic       dacSclk,
  input  wire logic       dacSyncN,
  input  wire logic       dacData,
  // Decoded results.
  output logic [9:0]      code,
  output logic [5:0]      pad,
  output int              frames
);
  logic [15:0] shift;  // Frame bits in arrival order.
  int          nBits;  // Bits taken in the current frame.

  initial begin
    code = 10'h000;
    pad = 6'h00;
    frames = 0;
    nBits = 0;
  end

  // sample on rise
  // Sampling on the rise leaves the whole low half for data to settle.
  always @(posedge dacSclk) begin
    if (!dacSyncN) begin
      shift = {shift[14:0], dacData};
      nBits = nBits + 1;
      if (nBits == 16) begin
        code = shift[13:4];
        pad = {shift[15:14], shift[3:0]};
        frames = frames + 1;
        nBits = 0;
      end
    end
  end

  // A sync release drops a partial frame, so a short frame is never counted.
  always @(posedge dacSyncN) nBits = 0;
endmodule // dsf_dac_model

// ===== verilog/dsf_feeder.sv
// Purpose: Feeds a single-channel 10-bit serial converter from a transmit queue.
// Assumes: audioRefClk is far slower than half ref_clk in simulation.
// Notes:   No software registers; control arrives as plain ports.
`timescale 1ns/1ps
module dsf_feeder
  import dsf_pkg::*;
#(
  parameter int FIFO_DEPTH = 8  // Queue depth, a power of two.
) (
  // Clock and reset.
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  // Audio reference pin and divider.
  input  wire logic                 audioRefClk,
  input  wire logic [DIV_W-1:0]     divRatio,
  // Pacing control.
  input  wire dsf_pace_type         paceMode,
  input  wire logic [TMR_W-1:0]     cmpPeriod,
  input  wire logic                 reqRouteDma,
  input  wire logic [$clog2(FIFO_DEPTH):0] watermark,
  // Sample writes from processor or DMA.
  input  wire logic                 wrValid,
  input  wire logic [CODE_W-1:0]    wrData,
  input  wire logic                 overflowClr,
  // Requests and status.
  output logic                      dmaReq_q,
  output logic                      irqReq_q,
  output logic                      emptyReq_q,
  output logic                      watermarkReq_q,
  output logic                      dmaTrigger_q,
  output logic                      overflowFlag_q,
  // Serial link to the converter.
  output logic                      dacSclk_q,
  output logic                      dacSyncN_q,
  output logic                      dacData_q
);

  localparam int PW = $clog2(FIFO_DEPTH);  // Pointer width.

  // ----------------------------------------------------------------------
  // Audio reference synchroniser
  // ----------------------------------------------------------------------
  logic       audS1_q, audS2_q, audS3_q;  // Three-stage sampler.
  logic       audLvl_q;                   // Filtered level.
  logic       audRise;                    // One-cycle rising edge.

  // The level only moves once the second and third stages agree.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      audS1_q  <= 1'b0;
      audS2_q  <= 1'b0;
      audS3_q  <= 1'b0;
      audLvl_q <= 1'b0;
    end else begin
      audS1_q <= audioRefClk;
      audS2_q <= audS1_q;
      audS3_q <= audS2_q;
      if (audS2_q == audS3_q) begin
        audLvl_q <= audS3_q;
      end
    end
  end

  assign audRise = (audS2_q == audS3_q) && audS3_q && !audLvl_q;

  // ----------------------------------------------------------------------
  // Bit-rate generator
  // ----------------------------------------------------------------------
  logic [DIV_W-1:0] ratioEff;    // Ratio clamped into the legal range.
  logic [DIV_W-1:0] divCnt_q;    // Reference edges within one bit.
  logic [DIV_W-1:0] divCnt_d;    // Next count.
  logic             bitStart_q;  // Pulse at each falling bit-clock edge.

  always_comb begin
    if (divRatio < DIV_MIN) begin
      ratioEff = DIV_MIN;
    end else if (divRatio > DIV_MAX) begin
      ratioEff = DIV_MAX;
    end else begin
      ratioEff = divRatio;
    end
    divCnt_d = (divCnt_q >= ratioEff - DIV_W'(1)) ? '0 : divCnt_q + DIV_W'(1);
  end

  // count reference edges.
  // The clock is low for the first ratioEff/2 reference edges of a bit, rounded down, and high for the rest.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      divCnt_q   <= '0;
      dacSclk_q  <= 1'b0;
      bitStart_q <= 1'b0;
    end else begin
      bitStart_q <= audRise && (divCnt_d == '0);
      if (audRise) begin
        divCnt_q  <= divCnt_d;
        dacSclk_q <= (divCnt_d >= (ratioEff >> 1));
      end
    end
  end

  // ----------------------------------------------------------------------
  // Transmit queue
  // ----------------------------------------------------------------------
  logic [CODE_W-1:0] mem [FIFO_DEPTH];  // Sample storage.
  logic [PW-1:0]     wrPtr_q, rdPtr_q;  // Queue pointers.
  logic [PW:0]       count_q, count_d;  // Occupancy.
  logic [PW:0]       capacity;          // Usable depth in this mode.
  logic              push, pop;         // Queue strobes.
  logic              startFrame;        // Shifter takes a sample.

  assign capacity = (paceMode == PACE_TIMER) ? (PW+1)'(1) : (PW+1)'(FIFO_DEPTH);
  // writes accepted whenever there is room.
  assign push     = wrValid && (count_q < capacity);
  assign pop      = startFrame;
  assign count_d  = count_q + (PW+1)'(push) - (PW+1)'(pop);

  // Pointers and storage; a write that finds no room is dropped.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      count_q <= count_d;
      if (push) begin
        mem[wrPtr_q] <= wrData;
        wrPtr_q      <= wrPtr_q + PW'(1);
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + PW'(1);
      end
    end
  end

  // sticky overflow, a new event beats the clear.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      overflowFlag_q <= 1'b0;
    end else if (wrValid && !push) begin
      overflowFlag_q <= 1'b1;
    end else if (overflowClr) begin
      overflowFlag_q <= 1'b0;
    end
  end

  // empty and watermark requests; in FIFO mode the watermark goes to DMA or interrupt.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      emptyReq_q     <= 1'b1;
      watermarkReq_q <= 1'b1;
      dmaReq_q       <= 1'b0;
      irqReq_q       <= 1'b0;
    end else begin
      emptyReq_q     <= (count_d == '0);
      watermarkReq_q <= (count_d <= watermark);
      dmaReq_q       <= (paceMode == PACE_FIFO) && (count_d <= watermark) && reqRouteDma;
      irqReq_q       <= (paceMode == PACE_FIFO) && (count_d <= watermark) && !reqRouteDma;
    end
  end

  // ----------------------------------------------------------------------
  // Compare-match timer
  // ----------------------------------------------------------------------
  logic [TMR_W-1:0] tmrCnt_q;  // Free count between matches.
  logic             tmrMatch;  // Count reached the compare value.

  assign tmrMatch = (paceMode == PACE_TIMER) && (tmrCnt_q >= cmpPeriod);

  // each match asks DMA for exactly one sample.
  always_ff @(posedge ref_clk) begin
    if (reset || paceMode != PACE_TIMER) begin
      tmrCnt_q     <= '0;
      dmaTrigger_q <= 1'b0;
    end else begin
      tmrCnt_q     <= tmrMatch ? '0 : tmrCnt_q + TMR_W'(1);
      dmaTrigger_q <= tmrMatch;
    end
  end

  // ----------------------------------------------------------------------
  // Serial shifter
  // ----------------------------------------------------------------------
  logic [FRAME_BITS-1:0] shift_q;   // Frame being sent.
  logic [BITCNT_W-1:0]   bitCnt_q;  // Bit index within the frame.
  logic                  busy_q;    // A frame is on the wire.

  // frames follow one idle bit apart while data waits, so the bit clock paces them.
  assign startFrame = bitStart_q && !busy_q && (count_q != '0);

  // MSB first, data moves on the falling bit-clock edge.
  // One idle bit with sync high separates frames, so a frame is 17 bit clocks.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shift_q    <= '0;
      bitCnt_q   <= '0;
      busy_q     <= 1'b0;
      dacSyncN_q <= 1'b1;
      dacData_q  <= 1'b0;
    end else if (startFrame) begin
      shift_q    <= {LEAD_ZEROS, mem[rdPtr_q], TRAIL_ZEROS};
      dacData_q  <= LEAD_ZEROS[1];
      bitCnt_q   <= '0;
      busy_q     <= 1'b1;
      dacSyncN_q <= 1'b0;
    end else if (bitStart_q && busy_q) begin
      if (bitCnt_q == LAST_BIT) begin
        busy_q     <= 1'b0;
        dacSyncN_q <= 1'b1;
        dacData_q  <= 1'b0;
      end else begin
        shift_q   <= {shift_q[FRAME_BITS-2:0], 1'b0};
        dacData_q <= shift_q[FRAME_BITS-2];
        bitCnt_q  <= bitCnt_q + BITCNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // sync lasts the full frame.
  frame_length_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(dacSyncN_q) |-> $past(bitCnt_q) == LAST_BIT)
    else $error("Frame sync released before the last bit.");

  // data never moves while the bit clock is high.
  data_stable_a: assert property (@(posedge ref_clk) disable iff (reset)
    $changed(dacData_q) |-> !dacSclk_q)
    else $error("Serial data changed with the bit clock high.");

  // timer mode holds one sample at most.
  timer_depth_a: assert property (@(posedge ref_clk) disable iff (reset)
    (paceMode == PACE_TIMER) && $stable(paceMode) && $past(count_q) <= 1 |-> count_q <= 1)
    else $error("Timer-paced queue held more than one sample.");

  // a refused write raises overflow next cycle.
  overflow_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
    wrValid && (count_q >= capacity) |=> overflowFlag_q)
    else $error("Refused write did not flag overflow.");

  // one trigger per match, low again on the following cycle.
  timer_trigger_a: assert property (@(posedge ref_clk) disable iff (reset)
    tmrMatch && $stable(paceMode) |=> dmaTrigger_q ##1 !dmaTrigger_q)
    else $error("Timer match did not give a single trigger.");

  empty_req_a: assert property (@(posedge ref_clk) disable iff (reset)
    emptyReq_q == (count_q == '0))
    else $error("Empty request disagrees with queue occupancy.");

  // requests go to exactly one destination.
  route_req_a: assert property (@(posedge ref_clk) disable iff (reset)
    dmaReq_q |-> !irqReq_q && $past(reqRouteDma))
    else $error("Request routed to the wrong destination.");

  // the frame opens with sync low and loads the code.
  frame_load_a: assert property (@(posedge ref_clk) disable iff (reset)
    startFrame |=> shift_q[CODE_LSB +: CODE_W] == $past(mem[rdPtr_q]) && !dacSyncN_q)
    else $error("Frame did not carry the queued code.");

  // bit starts only on a reference edge that wraps the divider.
  bit_start_a: assert property (@(posedge ref_clk) disable iff (reset)
    bitStart_q |-> divCnt_q == '0 && $past(audRise))
    else $error("Bit start without a divider wrap.");

endmodule // dsf_feeder

// ===== verilog/dsf_pkg.sv
// Purpose: Shared constants and types for the serial converter sample feeder.
// Assumes: One system clock of 20 MHz; the audio reference arrives as a pin.
// Notes:   Constants and one type; the list below names each behaviour.
// Behaviour
// - Bit clock divides audio reference, 1/2..1/1024.
// - FIFO-paced sample rate equals bit rate/frame.
// - FIFO raises empty/watermark requests, watermark to DMA or IRQ.
// - Compare timer match triggers one DMA sample write.
// - Timer-paced mode holds at most one sample.
// - Untimed set-point writes go out without pacing.
// - Each frame carries one 10-bit code.
package dsf_pkg;

  // ----------------------------------------------------------------------
  // Clock and divider limits
  // ----------------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ     = 20000000;  // System clock rate.
  localparam int unsigned AUDIO_REF_HZ   = 24576000;  // Default audio reference.
  localparam int unsigned FIXED_REF_HZ   = 12000000;  // Fixed board reference.
  localparam int          DIV_W          = 11;        // Width of the divide ratio.
  localparam logic [10:0] DIV_MIN        = 11'h002;   // Ratio 1/2.
  localparam logic [10:0] DIV_MAX        = 11'h400;   // Ratio 1/1024.

  // ----------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------
  localparam int          CODE_W         = 10;        // Converter resolution.
  localparam int          FRAME_BITS     = 16;        // Bit clocks with sync low.
  localparam int          CODE_LSB       = 4;         // Code sits in bits 13..4.
  localparam int          BITCNT_W       = 5;         // Bit counter width.
  localparam logic [4:0]  LAST_BIT       = 5'h0F;     // Index of the final bit.
  localparam logic [1:0]  LEAD_ZEROS     = 2'h0;      // Leading control bits.
  localparam logic [3:0]  TRAIL_ZEROS    = 4'h0;      // Trailing pad bits.

  // ----------------------------------------------------------------------
  // Timer and pacing
  // ----------------------------------------------------------------------
  localparam int          TMR_W          = 16;        // Compare timer width.

  // How samples are paced into the transmit queue.
  typedef enum logic [1:0] {
    PACE_FIFO,
    PACE_TIMER,
    PACE_UNTIMED
  } dsf_pace_type;

endpackage
